/* File: core/charge_port_mode_control.sv */
`timescale 1ns/1ns
`default_nettype none
module charge_port_mode_control #(
   parameter int unsigned FS_HOLD_CYCLES = charge_port_pkg::FS_HOLD_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic mode_select_bit_a,
   input wire logic mode_select_bit_b,
   input wire logic mode_select_bit_c,
   input wire logic limit_select,
   input wire logic enable,
   input wire logic dPlusHigh,
   input wire logic dMinusHigh,
   input wire logic loadSense,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic dataSwitchOn,
   output logic powerSwitchOn,
   output logic outputDrainOn,
   output logic highCurrentLimitOn,
   output logic powerWakeLimitOn,
   output logic autoChargeDetectOn,
   output logic [1:0] chargeScheme,
   output logic loadPresentN
);
   port_sense_if sense();

   // Pin synchroniser and deglitch
   input_filter uFilter (
      .clk(clk),
      .sys_rst(sys_rst),
      .rawPins({mode_select_bit_a, mode_select_bit_b, mode_select_bit_c, limit_select,
                enable, dPlusHigh, dMinusHigh, loadSense}),
      .sense(sense.filt)
   );

   // Low- and full-speed HID recognition
   hid_detect #(.FS_HOLD_CYCLES(FS_HOLD_CYCLES)) uHid (
      .clk(clk),
      .sys_rst(sys_rst),
      .sense(sense.hid)
   );

   charge_port_pkg::state_e stateR; // Sequencer state
   charge_port_pkg::mode_e modeR; // Mode in force
   charge_port_pkg::mode_e targetR; // Mode to enter after discharge
   logic [15:0] drainCntR; // Cycles spent discharging
   logic [15:0] drainLenR; // Software-set discharge length, CTRL register

   // Pin decode
   wire charge_port_pkg::mode_e pinMode =
      charge_port_pkg::decodeMode(sense.modeBits, sense.limitSel);
   wire logic running = (stateR == charge_port_pkg::ST_RUN);
   wire logic inStandard = charge_port_pkg::isStandard(modeR);
   wire logic hidKnown = sense.lsHid || sense.fsHid;
   // A known HID keeps the data path when pins ask for 011; limit pin plays no part
   wire logic overrideWake = running && inStandard && hidKnown && (sense.modeBits == 3'h3);
   // Pins are followed in every other case
   wire charge_port_pkg::mode_e targetMode = overrideWake ? modeR : pinMode;
   wire logic modeDiffers = (targetMode != modeR);
   // The second standard mode and charging-downstream swap without discharge
   wire logic quietSwap = charge_port_pkg::skipsDrain(modeR, targetMode);
   wire logic drainDone = (drainCntR >= drainLenR);

   // Watching the lines only makes sense while data can pass
   assign sense.monitorOn = running && inStandard;

   // Sequencer: reset parks in the initial state with output drained
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stateR <= charge_port_pkg::ST_INIT;
         modeR <= charge_port_pkg::MODE_OFF;
         targetR <= charge_port_pkg::MODE_OFF;
         drainCntR <= 16'h0000;
      end else begin
         case (stateR)
            // Leaving reset always passes a discharge into the pin-selected mode
            charge_port_pkg::ST_INIT: begin
               stateR <= charge_port_pkg::ST_DRAIN;
               targetR <= targetMode;
               drainCntR <= 16'h0000;
            end
            // Switch off and drain, then switch on in the new mode
            charge_port_pkg::ST_DRAIN: begin
               targetR <= targetMode;
               if (drainDone) begin
                  stateR <= charge_port_pkg::ST_RUN;
                  modeR <= targetMode;
               end else begin
                  drainCntR <= drainCntR + 16'h0001;
               end
            end
            // Any other change renegotiates current by a discharge, except the standard-second and charging-downstream swap
            default: begin
               if (modeDiffers && quietSwap) begin
                  modeR <= targetMode;
               end else if (modeDiffers) begin
                  stateR <= charge_port_pkg::ST_DRAIN;
                  targetR <= targetMode;
                  drainCntR <= 16'h0000;
               end
            end
         endcase
      end
   end

   // Output decode from the mode in force
   wire logic modeAuto = (modeR == charge_port_pkg::MODE_AUTO_DETECT);
   wire logic modeCdp = (modeR == charge_port_pkg::MODE_CHARGING_DOWNSTREAM);
   wire logic powerOnNxt = running && (modeR != charge_port_pkg::MODE_OFF);
   // Closed only in standard modes with enable high; open in discharge and
   // dedicated charging; current limiting has no say; charging-downstream
   // handshaking leaves it closed
   wire logic dataSwitchNxt = running && inStandard && sense.enable;
   // Auto mode from pins 001 with limit one swaps to the power-wake limit while no load
   wire logic pwrWakeNxt = running && modeAuto && (sense.modeBits == 3'h1)
      && sense.limitSel && !sense.loadSeen;
   // Limit select picks the limit except in fixed-limit modes
   wire logic highLimitNxt = modeAuto || modeCdp
      || (sense.limitSel && (modeR != charge_port_pkg::MODE_STANDARD_SECOND));
   // Load flag only in auto mode with limit one or charging-downstream
   wire logic loadFlagNxt = running && sense.loadSeen
      && ((modeAuto && sense.limitSel) || modeCdp);
   // Forced modes hold their scheme; auto starts in the low divider
   wire charge_port_pkg::scheme_e schemeNxt =
      (!running) ? charge_port_pkg::SCHEME_NONE :
      (modeR == charge_port_pkg::MODE_FORCED_SHORTED) ? charge_port_pkg::SCHEME_SHORTED :
      (modeAuto || (modeR == charge_port_pkg::MODE_FORCED_DIVIDER)) ?
         charge_port_pkg::SCHEME_DIVIDER_LOW : charge_port_pkg::SCHEME_NONE;

   // All port outputs come straight from flops; reset shows a drained port
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dataSwitchOn <= 1'b0;
         powerSwitchOn <= 1'b0;
         outputDrainOn <= 1'b1;
         highCurrentLimitOn <= 1'b0;
         powerWakeLimitOn <= 1'b0;
         autoChargeDetectOn <= 1'b0;
         chargeScheme <= charge_port_pkg::SCHEME_NONE;
         loadPresentN <= 1'b1;
      end else begin
         dataSwitchOn <= dataSwitchNxt;
         powerSwitchOn <= powerOnNxt;
         outputDrainOn <= !powerOnNxt;
         highCurrentLimitOn <= highLimitNxt;
         powerWakeLimitOn <= pwrWakeNxt;
         autoChargeDetectOn <= running && modeAuto;
         chargeScheme <= schemeNxt;
         loadPresentN <= !loadFlagNxt;
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY
   wire logic addrTaken = hsel && hready && htrans[1];
   logic wrPendR; // Write data phase in progress
   logic [7:0] wrAddrR; // Latched write address
   charge_port_pkg::status_s statusWord;

   always_comb begin
      statusWord = '0;
      statusWord.mode = modeR;
      statusWord.state = stateR;
      statusWord.scheme = charge_port_pkg::scheme_e'(chargeScheme);
      statusWord.lsHid = sense.lsHid;
      statusWord.fsHid = sense.fsHid;
      statusWord.drain = outputDrainOn;
      statusWord.powerOn = powerSwitchOn;
      statusWord.dataSwitch = dataSwitchOn;
      statusWord.limitHigh = highCurrentLimitOn;
      statusWord.autoDetect = autoChargeDetectOn;
      statusWord.loadPresentN = loadPresentN;
   end

   // Read mux; unmapped addresses read zero
   wire logic [31:0] readWord =
      (haddr[7:0] == charge_port_pkg::CTRL_OFFSET) ? {16'h0000, drainLenR} :
      (haddr[7:0] == charge_port_pkg::STATUS_OFFSET) ? statusWord :
      32'h0000_0000;

   // Read data is registered in the address phase so it stands in the data phase
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPendR <= 1'b0;
         wrAddrR <= 8'h00;
      end else begin
         hrdata <= (addrTaken && !hwrite) ? readWord : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPendR <= addrTaken && hwrite;
         wrAddrR <= haddr[7:0];
      end
   end

   // CTRL holds the discharge length; status is read only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         drainLenR <= charge_port_pkg::DRAIN_RESET;
      end else if (wrPendR && (wrAddrR == charge_port_pkg::CTRL_OFFSET)) begin
         drainLenR <= hwdata[15:0];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_switch_drain: assert property (dataSwitchOn |-> !outputDrainOn)
      else $error("data switch closed during discharge");
   chk_switch_mode: assert property (dataSwitchOn |-> $past(inStandard) && $past(sense.enable))
      else $error("data switch closed outside standard modes");
   chk_switch_open: assert property (!sense.enable || !inStandard |=> !dataSwitchOn)
      else $error("data switch not opened");
   chk_init_exit: assert property (stateR == charge_port_pkg::ST_INIT |=>
      stateR == charge_port_pkg::ST_DRAIN ##1 outputDrainOn)
      else $error("reset release did not enter discharge");
   chk_drain_off: assert property (stateR == charge_port_pkg::ST_DRAIN |=> !powerSwitchOn)
      else $error("power switch on during discharge");
   chk_drain_bound: assert property (stateR == charge_port_pkg::ST_DRAIN |->
      drainCntR <= drainLenR || drainLenR < $past(drainLenR))
      else $error("discharge ran past its length");
   chk_wake_hold: assert property (overrideWake |=> modeR == $past(modeR))
      else $error("HID override did not hold the mode");
   chk_quiet_swap: assert property (running && !overrideWake && quietSwap |=> running)
      else $error("standard-second swap caused a discharge");
   chk_follow_pins: assert property (running && modeDiffers && !quietSwap |=>
      stateR == charge_port_pkg::ST_DRAIN ##1 !powerSwitchOn)
      else $error("pin change not followed");
   chk_forced_fixed: assert property (running && modeR == charge_port_pkg::MODE_FORCED_SHORTED
      |=> chargeScheme == charge_port_pkg::SCHEME_SHORTED && !autoChargeDetectOn)
      else $error("forced shorted mode left its scheme");
   chk_limit_cdp: assert property (modeCdp |=> highCurrentLimitOn)
      else $error("charging-downstream without high limit");
   chk_load_off: assert property (!modeAuto && !modeCdp |=> loadPresentN)
      else $error("load flag asserted in a mode without load detection");

   // The slave never stalls and never reports an error
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer was not an immediate OKAY");

   // Control reads return the discharge length in the data phase
   chk_read_ctrl: assert property (addrTaken && !hwrite
      && haddr[7:0] == charge_port_pkg::CTRL_OFFSET
      |=> hrdata == {16'h0000, $past(drainLenR)})
      else $error("control read returned a wrong word");

   // Auto detection always opens in the low divider scheme
   chk_auto_scheme: assert property (running && modeAuto |=>
      chargeScheme == charge_port_pkg::SCHEME_DIVIDER_LOW && autoChargeDetectOn)
      else $error("auto mode did not start in the low divider");

   // Forced divider keeps its scheme and never runs auto detection
   chk_divider_fixed: assert property (running
      && modeR == charge_port_pkg::MODE_FORCED_DIVIDER
      |=> chargeScheme == charge_port_pkg::SCHEME_DIVIDER_LOW && !autoChargeDetectOn)
      else $error("forced divider mode left its scheme");

   // A load in charging-downstream pulls the load flag low
   chk_load_cdp: assert property (running && modeCdp && sense.loadSeen |=> !loadPresentN)
      else $error("charging-downstream load not flagged");

   // Auto 001 with limit one and no load falls back to the power-wake limit
   chk_pwake_limit: assert property (running && modeAuto && sense.modeBits == 3'h1
      && sense.limitSel && !sense.loadSeen |=> powerWakeLimitOn)
      else $error("power-wake limit not applied");
endmodule
`default_nettype wire

/* File: core/charge_port_pkg.sv */
// Functional notes
// - Forced modes stay fixed, no automatic detection
// - Data switch closed only in standard modes, enabled
// - Charging-downstream keeps data switch closed while handshaking
// - Open switch on disable, all-low pins, dedicated charging
// - Data switch open during any output discharge
// - Reset holds initial state with output discharged
// - After reset go to pin-selected mode
// - Mode changes discharge output, then switch on
// - Known HID device blocks move to 011
// - Detect low-speed and full-speed idle line levels
// - Full-speed only after 11 s without D+ drop
// - Follow mode pins always, except HID override
// - Decode mode pins into the seven modes
// - Current limit chosen by mode and limit select
// - Auto mode with limit one runs load detection
// - Charging-downstream load detection, otherwise flag off
// - Auto detection starts in the low divider scheme
// - No discharge between standard-second and charging-downstream
package charge_port_pkg;

   // Clock rate and derived timing
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned FS_HOLD_SEC = 11;
   localparam int unsigned FS_HOLD_CYCLES_DEF = FS_HOLD_SEC * CLK_MHZ * 1_000_000;
   localparam int unsigned DRAIN_TIME_NS = 10_000;
   localparam logic [15:0] DRAIN_RESET = 16'(DRAIN_TIME_NS * CLK_MHZ / 1000);
   // Pins must agree for one cycle more than this (last count value) before use
   localparam logic [2:0] FILTER_LAST = 3'h3;

   // Register map, byte addresses
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   typedef enum logic [2:0] {
      MODE_OFF, MODE_AUTO_DETECT, MODE_STANDARD_FIRST, MODE_STANDARD_SECOND,
      MODE_CHARGING_DOWNSTREAM, MODE_FORCED_SHORTED, MODE_FORCED_DIVIDER
   } mode_e;

   typedef enum logic [1:0] {ST_INIT, ST_DRAIN, ST_RUN} state_e;

   typedef enum logic [1:0] {SCHEME_NONE, SCHEME_DIVIDER_LOW, SCHEME_SHORTED} scheme_e;

   // Status word layout, low bits first from the bottom of the struct
   typedef struct packed {
      logic [16:0] reserved;
      logic loadPresentN;
      logic autoDetect;
      logic limitHigh;
      logic dataSwitch;
      logic powerOn;
      logic drain;
      logic fsHid;
      logic lsHid;
      scheme_e scheme;
      state_e state;
      mode_e mode;
   } status_s;

   // Pin decode; sel is {a, b, c}
   function automatic mode_e decodeMode(input logic [2:0] sel, input logic lim);
      case (sel)
         3'h0: decodeMode = MODE_OFF;
         3'h1, 3'h3: decodeMode = MODE_AUTO_DETECT;
         3'h2, 3'h6: decodeMode = MODE_STANDARD_FIRST;
         3'h4: decodeMode = MODE_FORCED_SHORTED;
         3'h5: decodeMode = MODE_FORCED_DIVIDER;
         default: decodeMode = lim ? MODE_CHARGING_DOWNSTREAM : MODE_STANDARD_SECOND;
      endcase
   endfunction

   // Modes that pass USB 2.0 data
   function automatic logic isStandard(input mode_e m);
      isStandard = (m == MODE_STANDARD_FIRST) || (m == MODE_STANDARD_SECOND)
         || (m == MODE_CHARGING_DOWNSTREAM);
   endfunction

   // Only the standard-second and charging-downstream pair skips discharge
   function automatic logic skipsDrain(input mode_e a, input mode_e b);
      skipsDrain = ((a == MODE_STANDARD_SECOND) && (b == MODE_CHARGING_DOWNSTREAM))
         || ((a == MODE_CHARGING_DOWNSTREAM) && (b == MODE_STANDARD_SECOND));
   endfunction

endpackage

/* File: core/port_sense_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Filtered pin levels and HID findings shared inside the block
interface port_sense_if;
   logic [2:0] modeBits; // {a, b, c}
   logic limitSel;
   logic enable;
   logic dPlus;
   logic dMinus;
   logic loadSeen;
   logic monitorOn; // Data lines are watched for HID devices
   logic lsHid;
   logic fsHid;
   modport filt(output modeBits, limitSel, enable, dPlus, dMinus, loadSeen);
   modport hid(input dPlus, dMinus, monitorOn, output lsHid, fsHid);
   modport ctrl(input modeBits, limitSel, enable, loadSeen, lsHid, fsHid, output monitorOn);
endinterface
`default_nettype wire

/* File: core/input_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module input_filter (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] rawPins,
   port_sense_if.filt sense
);
   logic [7:0] stage1R; // Metastability catcher, read only by stage2R
   logic [7:0] stage2R;
   logic [7:0] stage3R;
   logic [7:0] cleanR; // Accepted pin levels
   logic [2:0] stableCntR;

   // A change counts once stages two and three agree and differ from the clean copy
   wire logic agree = (stage2R == stage3R);
   wire logic differs = (stage3R != cleanR);
   wire logic settled = (stableCntR == charge_port_pkg::FILTER_LAST);

   // Synchroniser chain; reset value all-low means discharge mode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1R <= 8'h00;
         stage2R <= 8'h00;
         stage3R <= 8'h00;
      end else begin
         stage1R <= rawPins;
         stage2R <= stage1R;
         stage3R <= stage2R;
      end
   end

   // Glitch filter: any disagreement restarts the wait
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stableCntR <= 3'h0;
         cleanR <= 8'h00;
      end else if (!agree || !differs) begin
         stableCntR <= 3'h0;
      end else if (settled) begin
         stableCntR <= 3'h0;
         cleanR <= stage3R;
      end else begin
         stableCntR <= stableCntR + 3'h1;
      end
   end

   assign {sense.modeBits, sense.limitSel, sense.enable} = cleanR[7:3];
   assign {sense.dPlus, sense.dMinus, sense.loadSeen} = cleanR[2:0];

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_filter_settle: assert property ($changed(cleanR) |-> $past(stage3R) == cleanR)
      else $error("clean pins took a value not held by the sync chain");
endmodule
`default_nettype wire

/* File: core/hid_detect.sv */
`timescale 1ns/1ns
`default_nettype none
module hid_detect #(
   parameter int unsigned FS_HOLD_CYCLES = charge_port_pkg::FS_HOLD_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   port_sense_if.hid sense
);
   localparam logic [31:0] FS_LAST = 32'(FS_HOLD_CYCLES - 1);

   logic lsR; // Low-speed device seen
   logic fsR; // Full-speed device confirmed
   logic hsSeenR; // D+ dropped after connect: high-speed, never a wake source
   logic [31:0] holdCntR; // Cycles of full-speed idle so far

   wire logic lsIdle = sense.dMinus && !sense.dPlus;
   wire logic fsIdle = sense.dPlus && !sense.dMinus;
   wire logic connected = (holdCntR != 32'h0000_0000);

   // Findings survive only while the data lines are watched
   always_ff @(posedge clk) begin
      if (sys_rst || !sense.monitorOn) begin
         lsR <= 1'b0;
         fsR <= 1'b0;
         hsSeenR <= 1'b0;
         holdCntR <= 32'h0000_0000;
      end else begin
         // Low-speed is known at once from D- idling high
         if (lsIdle) begin
            lsR <= 1'b1;
         end
         // Full-speed needs the whole hold without a D+ drop
         if (!fsR && !hsSeenR) begin
            if (connected && !sense.dPlus) begin
               hsSeenR <= 1'b1;
               holdCntR <= 32'h0000_0000;
            end else if (fsIdle || connected) begin
               if (holdCntR == FS_LAST) begin
                  fsR <= 1'b1;
               end else begin
                  holdCntR <= holdCntR + 32'h0000_0001;
               end
            end
         end
      end
   end

   assign sense.lsHid = lsR;
   assign sense.fsHid = fsR;

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_ls_seen: assert property (sense.monitorOn && lsIdle ##1 sense.monitorOn |-> lsR)
      else $error("low-speed idle not recorded");
   chk_fs_window: assert property ($rose(fsR) |-> $past(holdCntR) == FS_LAST)
      else $error("full-speed confirmed before the hold time");
   chk_hs_blocks: assert property (hsSeenR |=> !$rose(fsR))
      else $error("high-speed device was classed as full-speed");
endmodule
`default_nettype wire

/* File: verif/usb_device_model.sv */
`timescale 1ns/1ns
`default_nettype none
module usb_device_model (
   input wire logic clk,
   input wire logic [1:0] kind, // 0 none, 1 low, 2 full, 3 high speed
   output logic dPlusHigh,
   output logic dMinusHigh
);
   logic [5:0] age_r = 6'h00; // Cycles since the attach
   logic [1:0] kindSeen_r = 2'h0; // Kind one cycle ago
   // Restart the age on every attach, so a high-speed device drops D+ once
   always_ff @(posedge clk) begin
      kindSeen_r <= kind;
      if (kind != kindSeen_r) begin
         age_r <= 6'h00;
      end else if (age_r != 6'h3f) begin
         age_r <= age_r + 6'h01;
      end
   end
   // Detached lines sit at ground through the host pull-downs
   assign dMinusHigh = (kind == 2'h1);
   // High speed drops its D+ pull-up after 20 cycles of negotiation
   assign dPlusHigh = (kind == 2'h2) || ((kind == 2'h3) && (age_r < 6'h14));
endmodule
`default_nettype wire

/* File: verif/charge_port_mode_control_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module charge_port_mode_control_tb_top;
   localparam int unsigned HOLD = 200; // Short full-speed hold for simulation
   logic clk, sys_rst, selA, selB, selC, limSel, enable, loadSense, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, chargeScheme, devKind;
   logic hreadyout, hresp, dataSwitchOn, powerSwitchOn, outputDrainOn, highLim;
   logic pwLim, autoOn, loadPresentN, dPlus, dMinus;
   logic [31:0] lfsr = 32'h0000_a1f8; // Fixed seed
   logic [31:0] expQ[$]; // Expected read words
   logic [31:0] maskQ[$]; // Bits that matter in each read
   logic rdPend = 1'b0; // A read is in its data phase
   int error_cnt = 0;
   int checks = 0;
   int drainCnt = 0; // Cycles seen with the output discharging
   int d0;
   logic [31:0] st;
   charge_port_mode_control #(.FS_HOLD_CYCLES(HOLD)) DUT (.clk(clk), .sys_rst(sys_rst),
      .mode_select_bit_a(selA), .mode_select_bit_b(selB), .mode_select_bit_c(selC),
      .limit_select(limSel), .enable(enable), .dPlusHigh(dPlus), .dMinusHigh(dMinus),
      .loadSense(loadSense), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .dataSwitchOn(dataSwitchOn),
      .powerSwitchOn(powerSwitchOn), .outputDrainOn(outputDrainOn),
      .highCurrentLimitOn(highLim), .powerWakeLimitOn(pwLim), .autoChargeDetectOn(autoOn),
      .chargeScheme(chargeScheme), .loadPresentN(loadPresentN));
   usb_device_model peer (.clk(clk), .kind(devKind), .dPlusHigh(dPlus), .dMinusHigh(dMinus));
   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Bounded wait for the slave's ready at a rising edge
   task automatic waitRdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         end_sim();
      end
   endtask
   // One single-word transfer; a read leaves its expectation in the queue
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
         input logic [31:0] m);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      if (!wr) begin
         expQ.push_back(d);
         maskQ.push_back(m);
      end
      waitRdy();
   endtask
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected status word from the pin table; p is {a, b, c, limit}
   function automatic logic [31:0] expStatus(input logic [3:0] p, input logic en,
         input logic ld);
      logic [2:0] m;
      logic lh;
      logic [1:0] sc;
      case (p[3:1])
         3'h0: m = 3'h0;
         3'h1, 3'h3: m = 3'h1;
         3'h2, 3'h6: m = 3'h2;
         3'h4: m = 3'h5;
         3'h5: m = 3'h6;
         default: m = p[0] ? 3'h4 : 3'h3;
      endcase
      lh = (m == 3'h1 || m == 3'h4) ? 1'b1 : ((m == 3'h3) ? 1'b0 : p[0]);
      sc = (m == 3'h1 || m == 3'h6) ? 2'h1 : ((m == 3'h5) ? 2'h2 : 2'h0);
      expStatus = {17'h0_0000, !(ld && p[0] && (m == 3'h1 || m == 3'h4)), m == 3'h1, lh,
         en && (m >= 3'h2) && (m <= 3'h4), m != 3'h0, m == 3'h0, 2'h0, sc, 2'h2, m};
   endfunction
   task automatic setPins(input logic [3:0] p, input logic en, input logic ld);
      {selA, selB, selC, limSel} <= p;
      enable <= en;
      loadSense <= ld;
   endtask
   // Result watcher: read data against the oldest note, drain against the data and power switches
   always @(posedge clk) begin
      if (rdPend && hreadyout === 1'b1 && expQ.size() > 0) begin
         check(hrdata & maskQ[0], expQ[0] & maskQ[0]);
         check({31'h0, hresp}, 32'h0000_0000);
         void'(expQ.pop_front());
         void'(maskQ.pop_front());
      end
      if (hreadyout === 1'b1) begin
         rdPend <= hsel && htrans[1] && !hwrite;
      end
      if (outputDrainOn === 1'b1) begin
         check({31'h0, dataSwitchOn | powerSwitchOn}, 32'h0000_0000);
         drainCnt++;
      end
   end
   // Hang guard
   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
   // Main sequence, acting as the system controller
   initial begin
      sys_rst = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata, devKind} = '0;
      setPins(4'h0, 1'b1, 1'b0);
      repeat (6) @(posedge clk);
      check({powerSwitchOn, outputDrainOn, dataSwitchOn}, 32'h0000_0002);
      sys_rst <= 1'b0;
      @(posedge clk);
      ahb(1'b0, 32'h0000_0000, 32'h0000_03e8, 32'h0000_ffff);
      ahb(1'b1, 32'h0000_0000, 32'h0000_0014, 32'h0000_0000);
      ahb(1'b0, 32'h0000_0000, 32'h0000_0014, 32'hffff_ffff);
      ahb(1'b0, 32'h0000_0040, 32'h0000_0000, 32'hffff_ffff);
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000, 32'h0000_0c00);
      $display("register test done");
      for (int i = 0; i < 16; i++) begin
         lfsr = nextRand(lfsr);
         d0 = drainCnt;
         setPins(4'(i), lfsr[3] | lfsr[9], lfsr[5]);
         repeat (60) @(posedge clk);
         if (i[0] == 1'b0 && i > 0) check(32'(drainCnt > d0), 32'h0000_0001);
         if (i == 15) check(32'(drainCnt), 32'(d0));
         st = expStatus(4'(i), lfsr[3] | lfsr[9], lfsr[5]);
         ahb(1'b0, 32'h0000_0004, st, (i < 2) ? 32'h0000_0e07 : 32'h0000_7fff);
         check({31'h0, pwLim}, {31'h0, i == 3 && !lfsr[5]});
      end
      $display("mode table test done");
      d0 = drainCnt;
      setPins(4'h0, 1'b1, 1'b0);
      @(posedge clk);
      @(posedge clk);
      setPins(4'hf, 1'b1, 1'b0);
      repeat (30) @(posedge clk);
      check(32'(drainCnt), 32'(d0));
      $display("glitch test done");
      devKind <= 2'h3;
      repeat (260) @(posedge clk);
      setPins(4'h6, 1'b1, 1'b0);
      repeat (60) @(posedge clk);
      ahb(1'b0, 32'h0000_0004, 32'h0000_0001, 32'h0000_0187);
      devKind <= 2'h2;
      setPins(4'hf, 1'b1, 1'b0);
      repeat (60) @(posedge clk);
      // Controller keeps a working mode past the full-speed hold before sleep
      repeat (HOLD + 60) @(posedge clk);
      setPins(4'h6, 1'b1, 1'b0);
      repeat (60) @(posedge clk);
      ahb(1'b0, 32'h0000_0004, 32'h0000_0104, 32'h0000_0187);
      $display("full-speed wake test done");
      devKind <= 2'h0;
      setPins(4'h0, 1'b1, 1'b0);
      repeat (60) @(posedge clk);
      setPins(4'h4, 1'b1, 1'b0);
      devKind <= 2'h1;
      repeat (60) @(posedge clk);
      setPins(4'h7, 1'b1, 1'b1);
      repeat (60) @(posedge clk);
      ahb(1'b0, 32'h0000_0004, 32'h0000_0882, 32'h0000_0987);
      // After wake the controller may move the pins at once
      setPins(4'hd, 1'b0, 1'b0);
      repeat (60) @(posedge clk);
      ahb(1'b0, 32'h0000_0004, 32'h0000_1002, 32'h0000_1807);
      $display("low-speed wake test done");
      end_sim();
   end
endmodule
`default_nettype wire
